// >>> verilog/cfg_pkg.sv
// Shared constants and state types for the configuration port ends
`default_nettype none
package cfg_pkg;
  localparam int CORE_PERIOD_NS = 50;
  localparam int CLEAR_TIME_NS = 2000;
  localparam int RESTART_TIME_NS = 500;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RESTART_CYCLES = (RESTART_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int LINK_HALF_CYCLES = 4;
  localparam int BUSY_LINK_CYCLES = 1;
  localparam int FRAME_BYTES = 16;
  localparam logic [7:0] CLEAR_CNT = 8'(CLEAR_CYCLES);
  localparam logic [7:0] RESTART_CNT = 8'(RESTART_CYCLES);
  localparam logic [7:0] HALF_CNT = 8'(LINK_HALF_CYCLES - 1);
  localparam logic [1:0] BUSY_CNT = 2'(BUSY_LINK_CYCLES);
  localparam logic [7:0] PREAMBLE = 8'h5a;
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_PARALLEL = 3'h6;
  typedef enum logic [1:0] {
    DEV_CLEAR = 2'h0,
    DEV_ARM = 2'h1,
    DEV_LOAD = 2'h2,
    DEV_DONE = 2'h3
  } dev_state_t;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'h0,
    HOST_RESTART = 3'h1,
    HOST_CLEAR = 3'h2,
    HOST_SEND = 3'h3,
    HOST_DONE = 3'h4
  } host_state_t;
endpackage
`default_nettype wire

// >>> verilog/cfg_link_if.sv
// Configuration port wires between the host and the device
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic host_clk;
  logic host_clk_oe;
  logic dev_clk;
  logic dev_clk_oe;
  logic config_clock;
  logic [7:0] host_byte;
  logic [7:0] host_byte_oe;
  logic [7:0] dev_byte;
  logic [7:0] dev_byte_oe;
  logic [7:0] config_byte_bus;
  logic [2:0] config_mode_select;
  logic restart_n;
  logic write_n;
  logic select_n;
  logic dev_done_oe;
  logic dev_clear_oe;
  logic done;
  logic clear_n;
  logic busy_dout;
  // Undriven wires read low; open-drain pins have a pull-up
  assign config_clock = (host_clk & host_clk_oe) | (dev_clk & dev_clk_oe);
  assign config_byte_bus = (host_byte & host_byte_oe) | (dev_byte & dev_byte_oe);
  assign done = ~dev_done_oe;
  assign clear_n = ~dev_clear_oe;
  modport device (
    input config_clock, config_byte_bus, config_mode_select, restart_n, write_n, select_n,
    output dev_clk, dev_clk_oe, dev_byte, dev_byte_oe, dev_done_oe, dev_clear_oe, busy_dout
  );
  modport host (
    input config_clock, config_byte_bus, done, clear_n, busy_dout,
    output host_clk, host_clk_oe, host_byte, host_byte_oe, config_mode_select, restart_n,
    output write_n, select_n
  );
endinterface
`default_nettype wire

// >>> verilog/cfg_sync2.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module cfg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk_i)
  begin
    meta <= d_i;
    q_o <= meta;
  end
endmodule
`default_nettype wire

// >>> verilog/cfg_dev_end.sv
// Device end of the configuration port: clear, load, completion, pin release
`timescale 1ns/1ps
`default_nettype none
module cfg_dev_end #(
  parameter int FRAME_BYTES = cfg_pkg::FRAME_BYTES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  cfg_link_if.device link,
  input wire logic retain_port_i,
  input wire logic [7:0] user_byte_i,
  input wire logic user_byte_oe_i,
  input wire logic user_busy_i,
  output logic [9:0] user_pins_o,
  output logic [2:0] mode_o,
  output logic [7:0] cfg_sum_o,
  output logic clearing_o,
  output logic done_o
);
  cfg_pkg::dev_state_t state, next_state;
  logic [7:0] clr_cnt, next_clr_cnt;
  logic [2:0] mode, next_mode;
  logic [7:0] sum, next_sum;
  logic [7:0] div, next_div;
  logic clk_q, next_clk_q;
  logic clk_oe, next_clk_oe;
  logic done_oe, next_done_oe;
  logic clear_oe, next_clear_oe;
  logic arm, next_arm;
  logic rel, next_rel;
  logic [9:0] pins, next_pins;
  logic master_run;
  logic par;
  logic [15:0] core_s;
  logic restart_s;
  logic [2:0] mode_s;
  logic loaded_s;
  logic ack_s;
  // Link-domain state, running on the configuration clock
  logic arm_l;
  logic found;
  logic next_found;
  logic [2:0] bits;
  logic [2:0] next_bits;
  logic [15:0] bytes;
  logic [15:0] next_bytes;
  logic [1:0] busy_cnt;
  logic [1:0] next_busy_cnt;
  logic loaded_l;
  logic next_loaded_l;
  logic ack_l;
  logic [7:0] sum_l;
  logic [7:0] next_sum_l;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic dout;
  logic next_dout;

  cfg_sync2 #(
    .WIDTH(16)
  ) u_core_sync (
    .clk_i(core_clk_i),
    .d_i({link.restart_n, link.config_mode_select, loaded_l, ack_l, link.select_n,
      link.write_n, link.config_byte_bus}),
    .q_o(core_s)
  );
  assign restart_s = core_s[15];
  assign mode_s = core_s[14:12];
  assign loaded_s = core_s[11];
  assign ack_s = core_s[10];

  cfg_sync2 #(
    .WIDTH(1)
  ) u_link_sync (
    .clk_i(link.config_clock),
    .d_i(arm),
    .q_o(arm_l)
  );

  // Mode is quasi-static to the link side: it only changes while unarmed
  assign par = (mode == cfg_pkg::MODE_PARALLEL);
  assign master_run = (state == cfg_pkg::DEV_CLEAR) ?
    (mode_s == cfg_pkg::MODE_MASTER_SERIAL) :
    (state != cfg_pkg::DEV_DONE && mode == cfg_pkg::MODE_MASTER_SERIAL);

  always_comb
  begin
    next_state = state;
    next_clr_cnt = clr_cnt;
    next_mode = mode;
    next_sum = sum;
    case (state)
      cfg_pkg::DEV_CLEAR:
      begin
        if (clr_cnt != cfg_pkg::CLEAR_CNT)
          next_clr_cnt = clr_cnt + 8'h01;
        else if (!ack_s && !loaded_s)
        begin
          next_mode = mode_s;
          next_state = cfg_pkg::DEV_ARM;
        end
      end
      cfg_pkg::DEV_ARM:
        if (ack_s)
          next_state = cfg_pkg::DEV_LOAD;
      cfg_pkg::DEV_LOAD:
        if (loaded_s)
        begin
          next_sum = sum_l;
          next_state = cfg_pkg::DEV_DONE;
        end
      cfg_pkg::DEV_DONE:
        next_state = cfg_pkg::DEV_DONE;
      default:
        next_state = cfg_pkg::DEV_CLEAR;
    endcase
    if (!restart_s)
    begin
      next_state = cfg_pkg::DEV_CLEAR;
      next_clr_cnt = 8'h00;
    end
    next_arm = (next_state == cfg_pkg::DEV_ARM) || (next_state == cfg_pkg::DEV_LOAD);
    next_clear_oe = (next_state == cfg_pkg::DEV_CLEAR) || (next_state == cfg_pkg::DEV_ARM);
    next_done_oe = (next_state != cfg_pkg::DEV_DONE);
    // Parallel pins stay with the port when retained serial pin always freed
    next_rel = (next_state == cfg_pkg::DEV_DONE) &&
      !(retain_port_i && next_mode == cfg_pkg::MODE_PARALLEL);
    next_pins = next_rel ? core_s[9:0] : 10'h000;
  end

  // Master-serial clock divider
  always_comb
  begin
    next_div = 8'h00;
    next_clk_q = 1'b0;
    next_clk_oe = master_run;
    if (master_run)
    begin
      next_div = (div == cfg_pkg::HALF_CNT) ? 8'h00 : div + 8'h01;
      next_clk_q = (div == cfg_pkg::HALF_CNT) ? ~clk_q : clk_q;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state <= cfg_pkg::DEV_CLEAR;
      clr_cnt <= 8'h00;
      mode <= cfg_pkg::MODE_SLAVE_SERIAL;
      sum <= 8'h00;
      div <= 8'h00;
      clk_q <= 1'b0;
      clk_oe <= 1'b0;
      done_oe <= 1'b1;
      clear_oe <= 1'b1;
      arm <= 1'b0;
      rel <= 1'b0;
      pins <= 10'h000;
    end
    else
    begin
      state <= next_state;
      clr_cnt <= next_clr_cnt;
      mode <= next_mode;
      sum <= next_sum;
      div <= next_div;
      clk_q <= next_clk_q;
      clk_oe <= next_clk_oe;
      done_oe <= next_done_oe;
      clear_oe <= next_clear_oe;
      arm <= next_arm;
      rel <= next_rel;
      pins <= next_pins;
    end
  end

  // Link side: cleared whenever the arm level is low
  always_comb
  begin
    next_found = found;
    next_bits = bits;
    next_bytes = bytes;
    next_busy_cnt = busy_cnt;
    next_sum_l = sum_l;
    next_sh = sh;
    next_dout = dout;
    if (!arm_l)
    begin
      next_found = 1'b0;
      next_bits = 3'h0;
      next_bytes = 16'h0000;
      next_busy_cnt = 2'h0;
      next_sum_l = 8'h00;
      next_sh = 8'h00;
      next_dout = 1'b0;
    end
    else if (par)
    begin
      if (busy_cnt != 2'h0)
        next_busy_cnt = busy_cnt - 2'h1;
      if (!link.select_n && !link.write_n && busy_cnt == 2'h0 && !loaded_l)
      begin
        next_sum_l = sum_l ^ link.config_byte_bus;
        next_bytes = bytes + 16'h0001;
        next_busy_cnt = cfg_pkg::BUSY_CNT;
      end
    end
    else
    begin
      next_dout = link.config_byte_bus[0];
      next_sh = {sh[6:0], link.config_byte_bus[0]};
      if (!found)
      begin
        if (next_sh == cfg_pkg::PREAMBLE)
          next_found = 1'b1;
      end
      else if (!loaded_l)
      begin
        next_bits = bits + 3'h1;
        if (bits == 3'h7)
        begin
          next_sum_l = sum_l ^ next_sh;
          next_bytes = bytes + 16'h0001;
        end
      end
    end
    next_loaded_l = arm_l && (loaded_l || next_bytes == 16'(FRAME_BYTES));
  end

  always_ff @(posedge link.config_clock)
  begin
    found <= next_found;
    bits <= next_bits;
    bytes <= next_bytes;
    busy_cnt <= next_busy_cnt;
    loaded_l <= next_loaded_l;
    ack_l <= arm_l;
    sum_l <= next_sum_l;
    sh <= next_sh;
    dout <= next_dout;
  end

  assign link.dev_clk = clk_q;
  assign link.dev_clk_oe = clk_oe;
  assign link.dev_done_oe = done_oe;
  assign link.dev_clear_oe = clear_oe;
  assign link.dev_byte = user_byte_i;
  assign link.dev_byte_oe = rel ? {8{user_byte_oe_i}} : 8'h00;
  // Busy drops once the frame is in, so a retained port is never stuck busy
  assign link.busy_dout = rel ? user_busy_i :
    (par ? (busy_cnt != 2'h0) && !loaded_l : dout);
  assign user_pins_o = pins;
  assign mode_o = mode;
  assign cfg_sum_o = sum;
  assign clearing_o = clear_oe;
  assign done_o = ~done_oe;
endmodule
`default_nettype wire

// >>> verilog/cfg_host_end.sv
// Host end of the configuration port: restart, mode, clocking and data
`timescale 1ns/1ps
`default_nettype none
module cfg_host_end (
  input wire logic core_clk_i,
  input wire logic srst_i,
  cfg_link_if.host link,
  input wire logic start_i,
  input wire logic [2:0] mode_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  output logic clearing_o,
  output logic done_o
);
  cfg_pkg::host_state_t state;
  cfg_pkg::host_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic restart_n;
  logic next_restart_n;
  logic clk_q;
  logic next_clk_q;
  logic clk_oe;
  logic next_clk_oe;
  logic [7:0] data_q;
  logic [7:0] next_data_q;
  logic [7:0] data_oe;
  logic [7:0] next_data_oe;
  logic write_n;
  logic next_write_n;
  logic select_n;
  logic next_select_n;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [2:0] bits;
  logic [2:0] next_bits;
  logic pre;
  logic next_pre;
  logic clk_d;
  logic [3:0] pin_s;
  logic clk_s;
  logic clear_s;
  logic done_s;
  logic busy_s;
  logic par;
  logic makes;
  logic fall;

  cfg_sync2 #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk_i(core_clk_i),
    .d_i({link.config_clock, link.clear_n, link.done, link.busy_dout}),
    .q_o(pin_s)
  );
  assign {clk_s, clear_s, done_s, busy_s} = pin_s;

  assign par = (mode == cfg_pkg::MODE_PARALLEL);
  // Host makes the clock during clear and send, except in master-serial mode
  assign makes = (state == cfg_pkg::HOST_CLEAR || state == cfg_pkg::HOST_SEND) &&
    (mode != cfg_pkg::MODE_MASTER_SERIAL);
  assign fall = makes ? (cnt == cfg_pkg::HALF_CNT && clk_q) : (clk_d && !clk_s);
  assign byte_ready_o = (state == cfg_pkg::HOST_SEND) && !done_s && fall && !pre &&
    (par ? !busy_s : bits == 3'h0);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_mode = mode;
    next_restart_n = restart_n;
    next_clk_q = 1'b0;
    next_data_q = data_q;
    next_data_oe = data_oe;
    next_write_n = write_n;
    next_select_n = select_n;
    next_sh = sh;
    next_bits = bits;
    next_pre = pre;
    case (state)
      cfg_pkg::HOST_IDLE, cfg_pkg::HOST_DONE:
        if (start_i)
        begin
          next_mode = mode_i;
          next_restart_n = 1'b0;
          next_cnt = 8'h00;
          next_state = cfg_pkg::HOST_RESTART;
        end
      cfg_pkg::HOST_RESTART:
        if (cnt == cfg_pkg::RESTART_CNT)
        begin
          next_restart_n = 1'b1;
          next_cnt = 8'h00;
          next_data_q = 8'hff;
          next_data_oe = par ? 8'hff : 8'h01;
          next_state = cfg_pkg::HOST_CLEAR;
        end
        else
          next_cnt = cnt + 8'h01;
      cfg_pkg::HOST_CLEAR:
        if (clear_s)
        begin
          next_select_n = !par;
          next_pre = !par;
          next_bits = 3'h0;
          next_state = cfg_pkg::HOST_SEND;
        end
      cfg_pkg::HOST_SEND:
        if (done_s)
        begin
          next_data_oe = 8'h00;
          next_write_n = 1'b1;
          next_select_n = 1'b1;
          next_state = cfg_pkg::HOST_DONE;
        end
        else if (fall && par)
        begin
          next_write_n = 1'b1;
          if (!busy_s && byte_valid_i)
          begin
            next_data_q = byte_i;
            next_write_n = 1'b0;
          end
        end
        else if (fall)
        begin
          if (bits != 3'h0)
          begin
            next_data_q[0] = sh[7];
            next_sh = {sh[6:0], 1'b0};
            next_bits = bits - 3'h1;
          end
          else if (pre || byte_valid_i)
          begin
            next_data_q[0] = pre ? cfg_pkg::PREAMBLE[7] : byte_i[7];
            next_sh = pre ? {cfg_pkg::PREAMBLE[6:0], 1'b0} : {byte_i[6:0], 1'b0};
            next_bits = 3'h7;
            next_pre = 1'b0;
          end
        end
      default:
        next_state = cfg_pkg::HOST_IDLE;
    endcase
    if (makes)
    begin
      next_cnt = (cnt == cfg_pkg::HALF_CNT) ? 8'h00 : cnt + 8'h01;
      next_clk_q = (cnt == cfg_pkg::HALF_CNT) ? ~clk_q : clk_q;
    end
    next_clk_oe = (next_state == cfg_pkg::HOST_CLEAR || next_state == cfg_pkg::HOST_SEND) &&
      (next_mode != cfg_pkg::MODE_MASTER_SERIAL);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state <= cfg_pkg::HOST_IDLE;
      cnt <= 8'h00;
      mode <= cfg_pkg::MODE_SLAVE_SERIAL;
      restart_n <= 1'b1;
      clk_q <= 1'b0;
      clk_oe <= 1'b0;
      data_q <= 8'hff;
      data_oe <= 8'h00;
      write_n <= 1'b1;
      select_n <= 1'b1;
      sh <= 8'h00;
      bits <= 3'h0;
      pre <= 1'b0;
      clk_d <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      mode <= next_mode;
      restart_n <= next_restart_n;
      clk_q <= next_clk_q;
      clk_oe <= next_clk_oe;
      data_q <= next_data_q;
      data_oe <= next_data_oe;
      write_n <= next_write_n;
      select_n <= next_select_n;
      sh <= next_sh;
      bits <= next_bits;
      pre <= next_pre;
      clk_d <= clk_s;
    end
  end

  assign link.host_clk = clk_q;
  assign link.host_clk_oe = clk_oe;
  assign link.host_byte = data_q;
  assign link.host_byte_oe = data_oe;
  assign link.config_mode_select = mode;
  assign link.restart_n = restart_n;
  assign link.write_n = write_n;
  assign link.select_n = select_n;
  assign clearing_o = !clear_s;
  assign done_o = (state == cfg_pkg::HOST_DONE);
endmodule
`default_nettype wire

// >>> dv/cfg_port_properties.sv
// Concurrent checks on the configuration port wires
`timescale 1ns/1ps
`default_nettype none
module cfg_port_properties (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic config_clock,
  input wire logic [2:0] config_mode_select,
  input wire logic restart_n,
  input wire logic write_n,
  input wire logic select_n,
  input wire logic clear_n,
  input wire logic done,
  input wire logic busy_dout,
  input wire logic [7:0] config_byte_bus,
  input wire logic [7:0] dev_byte_oe,
  input wire logic host_clk_oe,
  input wire logic dev_clk_oe
);
  logic par_load;
  logic ser_load;
  // Loading window of each mode family
  assign par_load = (config_mode_select == cfg_pkg::MODE_PARALLEL) && restart_n && clear_n && !done;
  assign ser_load = (config_mode_select != cfg_pkg::MODE_PARALLEL) && restart_n && clear_n && !done;

  clk_single_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !(host_clk_oe && dev_clk_oe)) else $error("both ends drive the link clock");
  restart_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(restart_n) |-> ##[1:6] !clear_n) else $error("clear not entered after restart");
  clear_stay_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !restart_n && !$past(restart_n, 6) |-> !clear_n) else $error("clear released too early");
  done_rise_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(done) |-> clear_n && restart_n) else $error("completion during clear");
  dev_quiet_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !done |-> dev_byte_oe == 8'h00) else $error("device drives data pins while loading");
  write_sel_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !write_n |-> !select_n) else $error("write without select");
  write_start_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(write_n) && par_load |-> !busy_dout) else $error("byte presented while busy");
  busy_width_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(busy_dout) && par_load |-> (busy_dout || done) [*6] ##[1:3] (!busy_dout || done))
    else $error("busy width wrong");
  daisy_fwd_a: assert property (@(posedge config_clock) disable iff (srst_i)
    ser_load && $past(clear_n) |-> busy_dout == $past(config_byte_bus[0]))
    else $error("daisy output does not repeat serial input");

  cover property (@(posedge core_clk_i) $rose(done) && !ser_load &&
    config_mode_select == cfg_pkg::MODE_PARALLEL);
  cover property (@(posedge core_clk_i) $rose(done) &&
    config_mode_select != cfg_pkg::MODE_PARALLEL);
  cover property (@(posedge core_clk_i) $rose(busy_dout) && par_load);
endmodule
`default_nettype wire

// >>> dv/test_config_port_pin_control.sv
// Self-checking bench joining the host and device ends of the configuration port
`timescale 1ns/1ps
`default_nettype none
module test_config_port_pin_control;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic retain_port_i = 1'b0;
  logic [7:0] user_byte_i = 8'h00;
  logic user_byte_oe_i = 1'b0;
  logic user_busy_i = 1'b0;
  logic start_i = 1'b0;
  logic [2:0] mode_i = 3'h0;
  logic [7:0] byte_i = 8'h00;
  logic byte_valid_i = 1'b0;
  logic byte_ready_o, host_clearing, host_done, dev_clearing, dev_done;
  logic [9:0] user_pins_o;
  logic [2:0] mode_o;
  logic [7:0] cfg_sum_o;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  cfg_link_if u_cfg_link_if ();
  cfg_dev_end #(.FRAME_BYTES(2)) u_cfg_dev_end (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .link(u_cfg_link_if), .retain_port_i(retain_port_i), .user_byte_i(user_byte_i),
    .user_byte_oe_i(user_byte_oe_i), .user_busy_i(user_busy_i), .user_pins_o(user_pins_o),
    .mode_o(mode_o), .cfg_sum_o(cfg_sum_o), .clearing_o(dev_clearing), .done_o(dev_done));
  cfg_host_end u_cfg_host_end (.core_clk_i(core_clk_i), .srst_i(srst_i), .link(u_cfg_link_if),
    .start_i(start_i), .mode_i(mode_i), .byte_i(byte_i), .byte_valid_i(byte_valid_i),
    .byte_ready_o(byte_ready_o), .clearing_o(host_clearing), .done_o(host_done));
  cfg_port_properties u_cfg_port_properties (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .config_clock(u_cfg_link_if.config_clock),
    .config_mode_select(u_cfg_link_if.config_mode_select),
    .restart_n(u_cfg_link_if.restart_n), .write_n(u_cfg_link_if.write_n),
    .select_n(u_cfg_link_if.select_n), .clear_n(u_cfg_link_if.clear_n), .done(u_cfg_link_if.done),
    .busy_dout(u_cfg_link_if.busy_dout), .config_byte_bus(u_cfg_link_if.config_byte_bus),
    .dev_byte_oe(u_cfg_link_if.dev_byte_oe), .host_clk_oe(u_cfg_link_if.host_clk_oe),
    .dev_clk_oe(u_cfg_link_if.dev_clk_oe));

  always #25 core_clk_i = ~core_clk_i;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One full configuration with two back-to-back bytes
  task automatic load(input logic [2:0] mode, input logic [7:0] b0, input logic [7:0] b1);
    int n;
    int t;
    logic taken;
    logic dev_drove;
    logic host_drove;
    n = 0;
    t = 0;
    dev_drove = 1'b0;
    host_drove = 1'b0;
    mode_i = mode;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    while (u_cfg_link_if.clear_n !== 1'b0 && t < 20)
    begin
      tick(1);
      t++;
    end
    check_bit("clear pin", 1'b0, u_cfg_link_if.clear_n);
    check_bit("done during clear", 1'b0, u_cfg_link_if.done);
    check_bit("device clearing", 1'b1, dev_clearing);
    tick(2);
    check_bit("host clearing", 1'b1, host_clearing);
    byte_valid_i = 1'b1;
    byte_i = b0;
    while (n < 2 && t < 4000)
    begin
      @(negedge core_clk_i);
      taken = byte_ready_o;
      if (u_cfg_link_if.dev_clk_oe === 1'b1) dev_drove = 1'b1;
      if (u_cfg_link_if.host_clk_oe === 1'b1) host_drove = 1'b1;
      tick(1);
      if (taken === 1'b1)
        n++;
      if (n > 0)
        byte_i = b1;
      t++;
    end
    byte_valid_i = 1'b0;
    while (host_done !== 1'b1 && t < 6000)
    begin
      tick(1);
      t++;
    end
    check_bit("device clock drive", mode == cfg_pkg::MODE_MASTER_SERIAL, dev_drove);
    check_bit("host clock drive", mode != cfg_pkg::MODE_MASTER_SERIAL, host_drove);
    check_bit("host done", 1'b1, host_done);
    check_bit("done pin", 1'b1, u_cfg_link_if.done);
    check_bit("device done", 1'b1, dev_done);
    check_bit("clear released", 1'b1, u_cfg_link_if.clear_n);
    check_bit("host clearing ended", 1'b0, host_clearing);
    check_byte("byte sum", b0 ^ b1, cfg_sum_o);
    check_byte("latched mode", {5'h00, mode}, {5'h00, mode_o});
  endtask

  task automatic test_parallel_release();
    retain_port_i = 1'b0;
    load(cfg_pkg::MODE_PARALLEL, 8'ha5, 8'h3c);
    user_byte_i = 8'hc3;
    user_byte_oe_i = 1'b1;
    user_busy_i = 1'b1;
    tick(4);
    check_byte("user data on pins", 8'hc3, u_cfg_link_if.config_byte_bus);
    check_byte("user data seen", 8'hc3, user_pins_o[7:0]);
    check_bit("user busy pin", 1'b1, u_cfg_link_if.busy_dout);
    check_bit("released select seen", 1'b1, user_pins_o[9]);
    user_byte_oe_i = 1'b0;
  endtask

  task automatic test_parallel_retain();
    retain_port_i = 1'b1;
    load(cfg_pkg::MODE_PARALLEL, 8'h0f, 8'hf0);
    user_byte_i = 8'h99;
    user_byte_oe_i = 1'b1;
    tick(4);
    check_byte("retained data enables", 8'h00, u_cfg_link_if.dev_byte_oe);
    check_byte("retained pins to user", 8'h00, user_pins_o[7:0]);
    check_bit("retained busy", 1'b0, u_cfg_link_if.busy_dout);
    user_byte_oe_i = 1'b0;
  endtask

  task automatic test_serial(input logic [2:0] mode, input logic [7:0] b0, input logic [7:0] b1);
    load(mode, b0, b1);
    user_byte_i = 8'h01;
    user_byte_oe_i = 1'b1;
    user_busy_i = 1'b0;
    tick(4);
    check_bit("serial pin to user", 1'b1, u_cfg_link_if.config_byte_bus[0]);
    check_bit("daisy pin to user", 1'b0, u_cfg_link_if.busy_dout);
    user_byte_oe_i = 1'b0;
  endtask

  initial
  begin
    tick(8);
    srst_i = 1'b0;
    test_parallel_release();
    test_parallel_retain();
    test_serial(cfg_pkg::MODE_SLAVE_SERIAL, 8'h81, 8'h7f);
    test_serial(cfg_pkg::MODE_MASTER_SERIAL, 8'hc6, 8'h5a);
    test_parallel_release();
    complete_run();
  end
endmodule
`default_nettype wire
